// File: hw/opc_clkrst.sv
// processor clock enable divider and panel reset combiner
`timescale 1ns/1ps
`default_nettype none
module opc_clkrst (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic host_panel_reset_n,
	input  wire logic local_reset_button,
	output logic      cpu_en,
	output logic      cpu_rst_n
);
	logic [1:0] div_reg, div_next;     // quarter-rate counter
	logic [1:0] hsync_reg, hsync_next; // host reset synchroniser
	logic [1:0] bsync_reg, bsync_next; // button synchroniser
	logic       rst_reg, rst_next;     // combined reset, active low

	// next values; power-up is the async reset itself
	always_comb
	begin
		div_next   = div_reg + 2'h1;
		hsync_next = {hsync_reg[0], host_panel_reset_n};
		bsync_next = {bsync_reg[0], local_reset_button};
		// only the second stage is looked at
		rst_next   = hsync_reg[1] & ~bsync_reg[1];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_reg   <= 2'h0;
			hsync_reg <= 2'h0;
			bsync_reg <= 2'h3;
			rst_reg   <= 1'b0;
		end
		else
		begin
			div_reg   <= div_next;
			hsync_reg <= hsync_next;
			bsync_reg <= bsync_next;
			rst_reg   <= rst_next;
		end
	end

	assign cpu_en    = (div_reg == 2'h3);
	assign cpu_rst_n = rst_reg;

	clk_div_a: assert property (@(posedge clk) disable iff (!arst_n)
		cpu_en |=> !cpu_en [*3] ##1 cpu_en)
		else $error("processor enable not one in four");
	button_rst_a: assert property (@(posedge clk) disable iff (!arst_n)
		local_reset_button [*4] |-> !cpu_rst_n)
		else $error("button press did not reset processor");
endmodule : opc_clkrst
`default_nettype wire

// File: hw/opc_panel_io.sv
// operator panel i/o controller: decoder, key matrix, adapter ports, readback
`timescale 1ns/1ps
`default_nettype none
module opc_panel_io #(
	parameter int unsigned SLIDER_PERIOD = opc_pkg::SLIDER_CYC,
	parameter logic [7:0]  BOARD_ID      = 8'h21, // arbitrary part/revision value
	parameter int unsigned ROWS          = opc_pkg::KEY_ROWS,
	parameter int unsigned NENC          = opc_pkg::ENCODERS
) (
	input  wire logic                          MCLK,
	input  wire logic                          ARST_N,
	input  wire logic                          HOST_PANEL_RESET_N,
	input  wire logic                          LOCAL_RESET_BUTTON,
	output logic                               CPU_CLK_EN,
	output logic                               CPU_RESET_N,
	input  wire opc_pkg::opc_bus_req_t         CPU_REQ,
	output logic [7:0]                         CPU_RDATA,
	output opc_pkg::opc_sel_t                  CHIP_SEL,
	input  wire logic [1:0]                    SERIAL_IRQ,
	output logic                               CPU_IRQ,
	input  wire logic [ROWS*8-1:0]             KEY_MATRIX_N,
	output logic [ROWS*8-1:0]                  KEY_LAMP_BOOST_N,
	input  wire logic [NENC*4-1:0]             ENC_GRAY,
	input  wire logic [3:0]                    TRACK_QUAD,
	input  wire logic [1:0]                    TOGGLE_SW,
	input  wire logic [4:0]                    REMOTE_CODE,
	input  wire logic                          REMOTE_CODE_VALID_N,
	input  wire logic                          AMBIENT_LIGHT_SENSOR,
	output logic                               SOUNDER_ON_N,
	output logic                               BACKLIGHT_ON_N,
	input  wire logic [7:0]                    SLIDER_DATA,
	output logic [2:0]                         SLIDER_CH,
	output logic                               SLIDER_SAMPLE
);
	logic        cpu_en;     // 50 MHz processor enable
	logic        cpu_rst_n;  // panel reset, synchronous to MCLK
	logic [7:0]  slider_rd;  // slider value at read address
	logic [15:0] a;          // request address shorthand
	logic        io_rd;      // read inside the i/o region
	logic        io_wr;      // write inside the i/o region

	assign a     = CPU_REQ.addr;
	assign io_rd = CPU_REQ.rd && (a < opc_pkg::RAM_BASE);
	assign io_wr = CPU_REQ.wr && (a < opc_pkg::RAM_BASE);

	// clock enable and reset source
	opc_clkrst u_clkrst (
		.clk                (MCLK),
		.arst_n             (ARST_N),
		.host_panel_reset_n (HOST_PANEL_RESET_N),
		.local_reset_button (LOCAL_RESET_BUTTON),
		.cpu_en             (cpu_en),
		.cpu_rst_n          (cpu_rst_n)
	);

	// slider converter with its own value store
	opc_slider_conv #(
		.PERIOD (SLIDER_PERIOD),
		.CHANS  (opc_pkg::SLIDERS)
	) u_slider (
		.clk      (MCLK),
		.arst_n   (ARST_N),
		.adc_data (SLIDER_DATA),
		.rd_ch    (a[2:0]),
		.cur_ch   (SLIDER_CH),
		.sample   (SLIDER_SAMPLE),
		.rd_data  (slider_rd)
	);

	assign CPU_CLK_EN  = cpu_en;
	assign CPU_RESET_N = cpu_rst_n;

	// ------------------------------------------------------------
	// chip select decode; upper regions go to stack RAM and ROM
	// ------------------------------------------------------------
	always_comb
	begin
		CHIP_SEL        = '0;
		CHIP_SEL.rom    = (a >= opc_pkg::ROM_BASE);
		CHIP_SEL.ram    = (a >= opc_pkg::RAM_BASE) && (a < opc_pkg::ROM_BASE);
		// serial controller: one channel host link, the other recorder
		CHIP_SEL.serial = (a[15:4] == opc_pkg::SERIAL_BASE[15:4]);
		// each display module has its own enable
		CHIP_SEL.lcd_a  = (a[15:3] == opc_pkg::LCD_A_BASE[15:3]);
		CHIP_SEL.lcd_b  = (a[15:3] == opc_pkg::LCD_B_BASE[15:3]);
	end

	// ------------------------------------------------------------
	// key matrix: sample, confirm on two equal scans, lamp boost
	// ------------------------------------------------------------
	logic [ROWS*8-1:0] key_smp_reg, key_smp_next; // last scan sample
	logic [ROWS*8-1:0] key_st_reg, key_st_next;   // confirmed state, low = pressed
	logic [ROWS*8-1:0] lamp_reg, lamp_next;       // lamp boost outputs

	// one scan per processor enable; a row changes only when two agree
	genvar gr;
	generate
		for (gr = 0; gr < ROWS; gr++)
		begin : g_row
			always_comb
			begin
				key_smp_next[gr*8 +: 8] = cpu_en ? KEY_MATRIX_N[gr*8 +: 8] : key_smp_reg[gr*8 +: 8];
				key_st_next[gr*8 +: 8]  = key_st_reg[gr*8 +: 8];
				if (cpu_en && (KEY_MATRIX_N[gr*8 +: 8] == key_smp_reg[gr*8 +: 8]))
					key_st_next[gr*8 +: 8] = key_smp_reg[gr*8 +: 8];
				// lamp follows the raw column level of a held key
				lamp_next[gr*8 +: 8] = KEY_MATRIX_N[gr*8 +: 8];
			end
		end
	endgenerate

	// idle lines are pulled high, so reset to all released
	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			key_smp_reg <= '1;
			key_st_reg  <= '1;
			lamp_reg    <= '1;
		end
		else
		begin
			key_smp_reg <= key_smp_next;
			key_st_reg  <= key_st_next;
			lamp_reg    <= lamp_next;
		end
	end

	assign KEY_LAMP_BOOST_N = lamp_reg;

	// ------------------------------------------------------------
	// parallel interface adapter: two ports, flags, enables, timer
	// ------------------------------------------------------------
	logic [7:0]  pb_reg, pb_next;         // port b output latch
	logic [2:0]  ifl_reg, ifl_next;       // sticky interrupt flags
	logic [2:0]  ie_reg, ie_next;         // interrupt enables
	logic [15:0] tmr_reg, tmr_next;       // running timer
	logic [15:0] tld_reg, tld_next;       // timer reload value
	logic [3:0]  quad_reg, quad_next;     // last trackball lines
	logic        rvn_reg, rvn_next;       // last remote strobe
	logic [4:0]  rcode_reg, rcode_next;   // captured remote key code
	logic        bl_reg, bl_next;         // backlight output
	logic        irq_reg, irq_next;       // processor interrupt
	logic        adp_wr;                  // write hits the adapter
	logic [3:0]  adp_idx;                 // adapter register index
	logic [2:0]  ev;                      // events seen this cycle

	assign adp_wr  = io_wr && (a[15:4] == opc_pkg::ADP_BASE[15:4]);
	assign adp_idx = a[3:0];

	always_comb
	begin
		// events: timer wrap, trackball motion, new remote key
		ev = 3'h0;
		ev[opc_pkg::IF_TIMER]  = cpu_en && (tmr_reg == 16'h0000);
		ev[opc_pkg::IF_TRACK]  = (TRACK_QUAD != quad_reg);
		ev[opc_pkg::IF_REMOTE] = rvn_reg && !REMOTE_CODE_VALID_N;
		pb_next    = pb_reg;
		ie_next    = ie_reg;
		tld_next   = tld_reg;
		ifl_next   = ifl_reg;
		quad_next  = TRACK_QUAD;
		rvn_next   = REMOTE_CODE_VALID_N;
		rcode_next = ev[opc_pkg::IF_REMOTE] ? REMOTE_CODE : rcode_reg;
		tmr_next   = cpu_en ? ((tmr_reg == 16'h0000) ? tld_reg : tmr_reg - 16'h0001) : tmr_reg;
		if (adp_wr)
		begin
			case (adp_idx)
				opc_pkg::ADP_PORT_B:  pb_next = CPU_REQ.wdata;
				opc_pkg::ADP_IFLAG:   ifl_next = ifl_reg & ~CPU_REQ.wdata[2:0];
				opc_pkg::ADP_IENABLE: ie_next = CPU_REQ.wdata[2:0];
				opc_pkg::ADP_TMR_LO:  tld_next[7:0] = CPU_REQ.wdata;
				opc_pkg::ADP_TMR_HI:
				begin
					// high byte write restarts the count
					tld_next[15:8] = CPU_REQ.wdata;
					tmr_next       = {CPU_REQ.wdata, tld_reg[7:0]};
				end
				default: ;
			endcase
		end
		// a flag raised in the clearing cycle survives
		ifl_next = ifl_next | ev;
		// dark room forces the backlight on regardless of port b
		bl_next  = pb_reg[opc_pkg::PB_BACKLIGHT] & ~AMBIENT_LIGHT_SENSOR;
		// adapter sources plus both serial channels
		irq_next = |(ifl_reg & ie_reg) | (|SERIAL_IRQ);
		// panel reset returns the adapter to its idle state
		if (!cpu_rst_n)
		begin
			pb_next  = opc_pkg::PB_RESET;
			ie_next  = opc_pkg::IE_RESET;
			ifl_next = 3'h0;
			tmr_next = opc_pkg::TMR_RESET;
			tld_next = opc_pkg::TMR_RESET;
			irq_next = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pb_reg    <= opc_pkg::PB_RESET;
			ifl_reg   <= 3'h0;
			ie_reg    <= opc_pkg::IE_RESET;
			tmr_reg   <= opc_pkg::TMR_RESET;
			tld_reg   <= opc_pkg::TMR_RESET;
			quad_reg  <= 4'h0;
			rvn_reg   <= 1'b1;
			rcode_reg <= 5'h00;
			bl_reg    <= 1'b1;
			irq_reg   <= 1'b0;
		end
		else
		begin
			pb_reg    <= pb_next;
			ifl_reg   <= ifl_next;
			ie_reg    <= ie_next;
			tmr_reg   <= tmr_next;
			tld_reg   <= tld_next;
			quad_reg  <= quad_next;
			rvn_reg   <= rvn_next;
			rcode_reg <= rcode_next;
			bl_reg    <= bl_next;
			irq_reg   <= irq_next;
		end
	end

	// sounder is on whenever its latch bit is low
	assign SOUNDER_ON_N   = pb_reg[opc_pkg::PB_SOUNDER];
	assign BACKLIGHT_ON_N = bl_reg;
	assign CPU_IRQ        = irq_reg;

	// ------------------------------------------------------------
	// read data: registered one cycle after the read strobe
	// ------------------------------------------------------------
	logic [7:0] rd_reg, rd_next; // read data latch
	logic [4:0] row_idx;         // key row within the window
	logic [7:0] enc_pair;        // two encoders at one address
	int unsigned ei;             // first encoder of the pair

	always_comb
	begin
		row_idx  = a[4:0];
		ei       = {29'h0, a[2:0]} * 2;
		enc_pair = 8'hFF;
		// unused encoder slots read as all ones
		if (ei + 1 < NENC)
			enc_pair = {ENC_GRAY[(ei+1)*4 +: 4], ENC_GRAY[ei*4 +: 4]};
		rd_next = rd_reg;
		if (io_rd)
		begin
			rd_next = opc_pkg::UNMAPPED;
			if (a[15:5] == opc_pkg::KEY_BASE[15:5] && row_idx < ROWS)
				rd_next = key_st_reg[row_idx*8 +: 8];
			else if (a[15:3] == opc_pkg::ENC_BASE[15:3])
				rd_next = enc_pair;
			else if (a[15:3] == opc_pkg::SLIDER_BASE[15:3])
				rd_next = slider_rd;
			else if (a == opc_pkg::BOARD_ID_ADR)
				rd_next = BOARD_ID;
			else if (a[15:4] == opc_pkg::ADP_BASE[15:4])
			begin
				case (adp_idx)
					// port a: remote code, strobe and toggles
					opc_pkg::ADP_PORT_A:  rd_next = {TOGGLE_SW, REMOTE_CODE_VALID_N, rcode_reg};
					// port b: latch bits plus trackball quadrature
					opc_pkg::ADP_PORT_B:  rd_next = {pb_reg[7:6], TRACK_QUAD, pb_reg[1:0]};
					opc_pkg::ADP_IFLAG:   rd_next = {5'h00, ifl_reg};
					opc_pkg::ADP_IENABLE: rd_next = {5'h00, ie_reg};
					opc_pkg::ADP_TMR_LO:  rd_next = tmr_reg[7:0];
					opc_pkg::ADP_TMR_HI:  rd_next = tmr_reg[15:8];
					default:              rd_next = opc_pkg::UNMAPPED;
				endcase
			end
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			rd_reg <= 8'h00;
		else
			rd_reg <= rd_next;
	end

	assign CPU_RDATA = rd_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);

	host_reset_a: assert property (!HOST_PANEL_RESET_N [*4] |-> !CPU_RESET_N)
		else $error("host reset not reaching processor");
	io_decode_a: assert property (CPU_REQ.rd && a == opc_pkg::LCD_A_BASE |->
		CHIP_SEL.lcd_a && !CHIP_SEL.lcd_b && !CHIP_SEL.ram && !CHIP_SEL.rom)
		else $error("display a decode wrong");
	lcd_split_a: assert property (!(CHIP_SEL.lcd_a && CHIP_SEL.lcd_b))
		else $error("both display enables at once");
	sounder_drive_a: assert property (cpu_rst_n && adp_wr && adp_idx == opc_pkg::ADP_PORT_B
		&& !CPU_REQ.wdata[0] |=> !SOUNDER_ON_N)
		else $error("sounder not driven low");
	backlight_dark_a: assert property (AMBIENT_LIGHT_SENSOR |=> !BACKLIGHT_ON_N)
		else $error("backlight off in the dark");
	lamp_boost_a: assert property ($fell(KEY_MATRIX_N[0]) |=> !KEY_LAMP_BOOST_N[0]
		&& KEY_LAMP_BOOST_N[0] == $past(KEY_MATRIX_N[0])) else $error("held key lamp not boosted");
	remote_capture_a: assert property (cpu_rst_n && $fell(REMOTE_CODE_VALID_N) |=> ##1
		rcode_reg == $past(REMOTE_CODE, 2) && ifl_reg[opc_pkg::IF_REMOTE])
		else $error("remote key not captured");
	track_flag_a: assert property (cpu_rst_n && TRACK_QUAD != quad_reg |=> ifl_reg[opc_pkg::IF_TRACK])
		else $error("trackball motion not flagged");
	irq_out_a: assert property (cpu_rst_n && (|SERIAL_IRQ) |=> CPU_IRQ)
		else $error("serial request not forwarded");
	key_row_a: assert property (CPU_REQ.rd && a == opc_pkg::KEY_BASE |=>
		CPU_RDATA == $past(key_st_reg[7:0])) else $error("row 0 readback wrong");
	board_id_a: assert property (CPU_REQ.rd && a == opc_pkg::BOARD_ID_ADR |=> CPU_RDATA == BOARD_ID)
		else $error("board id readback wrong");

	key_press_c: cover property (cpu_en && KEY_MATRIX_N[7:0] != 8'hFF ##[1:8] key_st_reg[7:0] != 8'hFF);
	remote_key_c: cover property ($fell(REMOTE_CODE_VALID_N) ##[1:4] CPU_IRQ);
	timer_wrap_c: cover property (ifl_reg[opc_pkg::IF_TIMER]);
endmodule : opc_panel_io
`default_nettype wire

// File: hw/opc_pkg.sv
// shared constants, address map and carrier types for the operator panel i/o block
// Function
// - processor clock is crystal divided by four
// - interrupts from timer, trackball, remote, serial ports
// - reset from host line, button or power-up
// - low addresses are i/o, upper RAM and ROM
// - read-only board part and revision location
// - sounder sounds while its output is low
// - backlight forced on when ambient light low
// - held key boosts its own lamp current
// - trackball moves interrupt; quadrature lines readable
// - both toggle switch states readable
// - remote distinguishes up to 32 key codes
// - remote code on five lines with valid strobe
// - eight sliders converted, new value every 9 ms
// - slider values kept in dual-port memory
// - 23 by 8 key matrix, row per address
// - column reads zero when key pressed
// - encoders read in pairs as 4-bit gray
// - separate enables for both character displays
// - adapter gives two 8-bit parallel ports
// - two serial ports: host link and recorder
package opc_pkg;

	// clock and derived timing
	localparam int unsigned CLK_HZ       = 200_000_000;
	localparam int unsigned CPU_DIV      = 4;
	localparam int unsigned SLIDER_MS    = 9;
	localparam int unsigned SLIDER_CYC   = (CLK_HZ / 1000) * SLIDER_MS;
	localparam int unsigned RST_SYNC     = 2;

	// panel sizes
	localparam int unsigned KEY_ROWS     = 23;
	localparam int unsigned KEY_COLS     = 8;
	localparam int unsigned KEY_MAX      = 192;
	localparam int unsigned REMOTE_KEYS  = 32;
	localparam int unsigned REMOTE_W     = 5;
	localparam int unsigned SLIDERS      = 8;
	localparam int unsigned ENCODERS     = 8;
	localparam int unsigned ENC_W        = 4;

	// address map: i/o below RAM_BASE, ROM from ROM_BASE
	localparam logic [15:0] KEY_BASE     = 16'h0000;
	localparam logic [15:0] ENC_BASE     = 16'h0020;
	localparam logic [15:0] SLIDER_BASE  = 16'h0030;
	localparam logic [15:0] ADP_BASE     = 16'h0040;
	localparam logic [15:0] BOARD_ID_ADR = 16'h0050;
	localparam logic [15:0] SERIAL_BASE  = 16'h0060;
	localparam logic [15:0] LCD_A_BASE   = 16'h0070;
	localparam logic [15:0] LCD_B_BASE   = 16'h0078;
	localparam logic [15:0] RAM_BASE     = 16'h1000;
	localparam logic [15:0] ROM_BASE     = 16'h8000;

	// adapter register indices
	localparam logic [3:0]  ADP_PORT_A   = 4'h0;
	localparam logic [3:0]  ADP_PORT_B   = 4'h1;
	localparam logic [3:0]  ADP_IFLAG    = 4'h2;
	localparam logic [3:0]  ADP_IENABLE  = 4'h3;
	localparam logic [3:0]  ADP_TMR_LO   = 4'h4;
	localparam logic [3:0]  ADP_TMR_HI   = 4'h5;

	// port b output bits and interrupt flag bits
	localparam int unsigned PB_SOUNDER   = 0;
	localparam int unsigned PB_BACKLIGHT = 1;
	localparam int unsigned IF_TIMER     = 0;
	localparam int unsigned IF_TRACK     = 1;
	localparam int unsigned IF_REMOTE    = 2;

	// reset values
	localparam logic [7:0]  PB_RESET     = 8'hFF;
	localparam logic [2:0]  IE_RESET     = 3'h0;
	localparam logic [15:0] TMR_RESET    = 16'hFFFF;
	localparam logic [7:0]  UNMAPPED     = 8'hFF;

	// processor bus request carrier
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} opc_bus_req_t;

	// chip selects toward external parts
	typedef struct packed {
		logic ram;
		logic rom;
		logic serial;
		logic lcd_a;
		logic lcd_b;
	} opc_sel_t;

endpackage : opc_pkg

// File: hw/opc_slider_conv.sv
// slider conversion sequencer with its own dual-port value store
`timescale 1ns/1ps
`default_nettype none
module opc_slider_conv #(
	parameter int unsigned PERIOD = opc_pkg::SLIDER_CYC,
	parameter int unsigned CHANS  = opc_pkg::SLIDERS
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] adc_data,
	input  wire logic [2:0] rd_ch,
	output logic [2:0]      cur_ch,
	output logic            sample,
	output logic [7:0]      rd_data
);
	logic [31:0] cnt_reg, cnt_next; // period counter
	logic [2:0]  ch_reg, ch_next;   // channel being converted
	logic [7:0]  mem [CHANS];       // converted values, one per slider
	logic        tick;              // end of one conversion period

	assign tick = (cnt_reg == PERIOD - 1);

	// period and channel rotation
	always_comb
	begin
		cnt_next = tick ? 32'h0 : cnt_reg + 32'h1;
		ch_next  = tick ? ch_reg + 3'h1 : ch_reg;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg <= 32'h0;
			ch_reg  <= 3'h0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			ch_reg  <= ch_next;
		end
	end

	// write side stores a result; no reset so it maps onto ram
	always_ff @(posedge clk)
	begin
		if (tick)
			mem[ch_reg] <= adc_data;
	end

	// read side is independent of conversion timing
	assign rd_data = mem[rd_ch];
	assign cur_ch  = ch_reg;
	assign sample  = tick;

	slider_store_a: assert property (@(posedge clk) disable iff (!arst_n)
		tick |=> mem[$past(ch_reg)] == $past(adc_data) && ch_reg == $past(ch_reg) + 3'h1)
		else $error("slider value not stored or channel not advanced");
	slider_cover_c: cover property (@(posedge clk) disable iff (!arst_n) tick && ch_reg == 3'h7);
endmodule : opc_slider_conv
`default_nettype wire

// File: sim/opc_panel_io_bench.sv
// self-checking bench for the operator panel i/o block
`timescale 1ns/1ps
`default_nettype none
module opc_panel_io_bench;
	logic                  mclk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  host_rst_n = 1'b1;
	logic                  button = 1'b0;
	opc_pkg::opc_bus_req_t req = '0;
	logic [1:0]            serial_irq = 2'h0;
	logic [3:0]            quad = 4'h0;
	logic                  dark = 1'b0;
	logic [7:0]            slider = 8'h00;
	logic [7:0]            press_idx = 8'h00;
	logic                  press = 1'b0;
	logic                  send = 1'b0;
	logic [4:0]            code_in = 5'h00;
	logic [183:0]          key_n, lamp_n;
	logic [4:0]            code;
	logic                  valid_n, clk_en, rst_n, irq, snd_n, bl_n;
	logic [7:0]            rdata, v;
	logic [2:0]            sch;
	opc_pkg::opc_sel_t     sel;
	logic [15:0]           sa [5] = '{16'h0070, 16'h0078, 16'h0060, 16'h1000, 16'h8000};
	logic [4:0]            se [5] = '{5'h02, 5'h01, 5'h04, 5'h10, 5'h08};
	int                    n_fail = 0;
	int                    samples_checked = 0;
	int                    cnt;

	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	// converter result tagged with its channel
	always @(posedge mclk) slider <= 8'hA0 + {5'h00, sch};

	opc_panel_io #(.SLIDER_PERIOD(20), .BOARD_ID(8'h5A)) dut_u (
		.MCLK(mclk), .ARST_N(arst_n), .HOST_PANEL_RESET_N(host_rst_n), .LOCAL_RESET_BUTTON(button),
		.CPU_CLK_EN(clk_en), .CPU_RESET_N(rst_n), .CPU_REQ(req), .CPU_RDATA(rdata), .CHIP_SEL(sel),
		.SERIAL_IRQ(serial_irq), .CPU_IRQ(irq), .KEY_MATRIX_N(key_n), .KEY_LAMP_BOOST_N(lamp_n),
		.ENC_GRAY(32'h76543210), .TRACK_QUAD(quad), .TOGGLE_SW(2'h2), .REMOTE_CODE(code),
		.REMOTE_CODE_VALID_N(valid_n), .AMBIENT_LIGHT_SENSOR(dark), .SOUNDER_ON_N(snd_n),
		.BACKLIGHT_ON_N(bl_n), .SLIDER_DATA(slider), .SLIDER_CH(sch), .SLIDER_SAMPLE());

	opc_panel_model model_u (.clk(mclk), .press_idx(press_idx), .press(press), .send(send),
		.code_in(code_in), .key_n(key_n), .code(code), .valid_n(valid_n));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one read cycle, data settles at the edge after the request
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge mclk);
		req.rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge mclk);
		req.wr    <= 1'b0;
		#1;
	endtask : wr

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// hang guard
	initial
	begin
		#100000;
		n_fail++;
		stop_test();
	end

	initial
	begin
		cyc(16);
		arst_n <= 1'b1;
		cyc(4);
		cnt = 0;
		repeat (40)
		begin
			cyc(1);
			#1 cnt += int'(clk_en);
		end
		chk(8'(cnt), 8'h0A, "cpu clock enables");
		rd(16'h0050, v);
		chk(v, 8'h5A, "board id");
		cyc(1);
		press_idx <= 8'h2B;
		press     <= 1'b1;
		cyc(20);
		rd(16'h0005, v);
		chk(v, 8'hF7, "key row 5");
		chk({7'h00, lamp_n[43]}, 8'h00, "lamp boost");
		rd(16'h0017, v);
		chk(v, 8'hFF, "row 23");
		cyc(1);
		press <= 1'b0;
		cyc(20);
		rd(16'h0005, v);
		chk(v, 8'hFF, "released row");
		for (int k = 0; k < 4; k++)
		begin
			rd(16'h0020 + 16'(k), v);
			chk(v, 8'(34 * k + 16), "encoder pair");
		end
		wr(16'h0041, 8'hFE);
		chk({6'h00, snd_n, bl_n}, 8'h01, "sounder on");
		cyc(1);
		dark <= 1'b1;
		cyc(2);
		#1 chk({7'h00, bl_n}, 8'h00, "backlight dark");
		wr(16'h0043, 8'h04);
		cyc(1);
		code_in <= 5'h0C;
		send    <= 1'b1;
		cyc(1);
		send    <= 1'b0;
		cnt = 0;
		while (irq !== 1'b1 && cnt < 10)
		begin
			cyc(1);
			#1 cnt++;
		end
		if (cnt == 10)
		begin
			n_fail++;
			stop_test();
		end
		cyc(6);
		rd(16'h0040, v);
		chk(v, {2'h2, 1'b1, 5'h0C}, "port a");
		wr(16'h0042, 8'h04);
		wr(16'h0043, 8'h00);
		cyc(2);
		#1 chk({7'h00, irq}, 8'h00, "irq cleared");
		cyc(1);
		quad <= 4'h1;
		cyc(4);
		rd(16'h0042, v);
		chk(v & 8'h06, 8'h02, "trackball flag");
		cyc(1);
		serial_irq <= 2'h2;
		cyc(3);
		#1 chk({7'h00, irq}, 8'h01, "serial irq");
		for (int i = 0; i < 5; i++)
		begin
			cyc(1);
			req.addr <= sa[i];
			cyc(1);
			#1 chk({3'h0, sel}, {3'h0, se[i]}, "chip select");
		end
		cyc(200);
		for (int i = 0; i < 8; i++)
		begin
			rd(16'h0030 + 16'(i), v);
			chk(v, 8'hA0 + 8'(i), "slider");
		end
		cyc(1);
		button <= 1'b1;
		cyc(6);
		#1 chk({6'h00, rst_n, snd_n}, 8'h01, "button reset");
		cyc(1);
		button     <= 1'b0;
		host_rst_n <= 1'b0;
		cyc(6);
		#1 chk({7'h00, rst_n}, 8'h00, "host reset");
		cyc(1);
		host_rst_n <= 1'b1;
		cyc(6);
		#1 chk({7'h00, rst_n}, 8'h01, "reset release");
		stop_test();
	end
endmodule : opc_panel_io_bench
`default_nettype wire

// File: sim/opc_panel_model.sv
// panel-side model: pulled-up key matrix and remote receiver
`timescale 1ns/1ps
`default_nettype none
module opc_panel_model (
	input  wire logic         clk,
	input  wire logic [7:0]   press_idx,
	input  wire logic         press,
	input  wire logic         send,
	input  wire logic [4:0]   code_in,
	output logic [183:0]      key_n,
	output logic [4:0]        code,
	output var logic          valid_n
);
	logic [4:0] last_reg = 5'h00; // last code sent
	logic [2:0] hold_reg = 3'h0;  // strobe cycles left
	// columns idle high, a pressed key pulls its own line low
	always_comb
	begin
		key_n = '1;
		if (press)
			key_n[press_idx] = 1'b0;
	end
	// strobe stays low for four cycles per decoded key
	always_ff @(posedge clk)
	begin
		if (send)
		begin
			last_reg <= code_in;
			hold_reg <= 3'h4;
		end
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
	end
	assign valid_n = (hold_reg == 3'h0);
	// outside the strobe the lines carry junk, never the last code
	assign code    = valid_n ? ~last_reg : last_reg;
endmodule : opc_panel_model
`default_nettype wire
